// File: core/dbg_pkg.sv
package dbg_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
	localparam logic [11:0] ADDR_BP0 = 12'h010;
	localparam logic [11:0] ADDR_BP3 = 12'h01C;
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [31:0] BP_RST = 32'h0000_0000;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	// ---------------------------------------------------------------
	// Breakpoint word fields
	// ---------------------------------------------------------------
	localparam int BPF_ADDR = 0;
	localparam int BPF_DATA = 16;
	localparam int BPF_EN = 24;
	localparam int BPF_RD = 25;
	localparam int BPF_WR = 26;
	localparam int BPF_SPM = 27;
	// ---------------------------------------------------------------
	// Configuration fields
	// ---------------------------------------------------------------
	localparam int CF_RANGE = 0;
	localparam int CF_OUTSIDE = 1;
	localparam int CF_AND = 2;
	localparam int CF_PSEL = 3;
	localparam int CF_COMB = 5;
	localparam int CF_EVOUT = 6;
	localparam int CF_EVHALT = 7;
	localparam int CF_HALT = 8;
	localparam int CF_EVT = 12;
	localparam int CF_TRACE = 16;
	// ---------------------------------------------------------------
	// Interrupt status bits
	// ---------------------------------------------------------------
	localparam int IRQ_BRK = 0;
	localparam int IRQ_EXT = 1;
	localparam int IRQ_DONE = 2;
	// ---------------------------------------------------------------
	// Serial frame layout
	// ---------------------------------------------------------------
	localparam int FRAME_W = 40;
	localparam int FR_OP = 36;
	localparam int FR_SPACE = 33;
	localparam int FR_ADDR = 16;
	localparam int FR_DATA = 0;
	localparam int FO_TRACE_V = 39;
	localparam int FO_HALTED = 38;
	localparam int FO_RDATA_V = 37;
	localparam int FO_PC = 16;
	localparam int FO_RDATA = 8;
	typedef enum logic [2:0] {
		SP_CODE = 3'h0,
		SP_SFR = 3'h1,
		SP_DIRECT = 3'h2,
		SP_INDIRECT = 3'h3,
		SP_EXT = 3'h4,
		SP_COREREG = 3'h5
	} space_e;
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_HALT = 4'h1,
		OP_RUN = 4'h2,
		OP_RESET = 4'h3,
		OP_STEP = 4'h4,
		OP_READ = 4'h5,
		OP_WRITE = 4'h6
	} op_e;
endpackage

// File: core/core_access_if.sv
`timescale 1ns/1ns
interface core_access_if;
	logic valid;
	logic write;
	logic [2:0] space;
	logic [15:0] addr;
	logic [7:0] data;
	modport src (output valid, output write, output space, output addr, output data);
	modport mon (input valid, input write, input space, input addr, input data);
endinterface

// File: core/bp_match.sv
`timescale 1ns/1ns
module bp_match
	import dbg_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Observed core access
	core_access_if.mon acc,
	// Settings
	input wire logic [31:0] bp_word [4],
	input wire logic [31:0] cfg,
	// Results
	output logic brk_halt_r,
	output logic brk_event_r,
	output logic [3:0] hit_r
);
	// Access type and memory space qualification of one comparator.
	function automatic logic qual(input logic [31:0] w);
		logic sp_ok;
		sp_ok = (acc.space <= SP_EXT) && w[BPF_SPM + int'(acc.space)];
		return w[BPF_EN] & acc.valid & (acc.write ? w[BPF_WR] : w[BPF_RD]) & sp_ok;
	endfunction

	wire [15:0] lo = bp_word[0][BPF_ADDR +: 16];
	wire [15:0] hi = bp_word[1][BPF_ADDR +: 16];
	wire in_range = (acc.addr >= lo) && (acc.addr <= hi);
	wire range_m = qual(bp_word[0]) & (in_range ^ cfg[CF_OUTSIDE]);
	wire [2:0] am;
	assign am[0] = cfg[CF_RANGE] ? range_m : qual(bp_word[0]) & (acc.addr == lo);
	assign am[1] = ~cfg[CF_RANGE] & qual(bp_word[1]) & (acc.addr == hi);
	assign am[2] = qual(bp_word[2]) & (acc.addr == bp_word[2][BPF_ADDR +: 16]);
	wire dm = qual(bp_word[3]) & (acc.addr == bp_word[3][BPF_ADDR +: 16])
		& (acc.data == bp_word[3][BPF_DATA +: 8]);
	wire [1:0] psel = cfg[CF_PSEL +: 2];
	wire comb = cfg[CF_COMB] & (psel != 2'h3);
	wire partner = (psel == 2'h3) ? 1'b0 : am[psel];
	wire comb_m = cfg[CF_AND] ? (dm & partner) : (dm | partner);
	// A partner that is combined only acts through the combined term.
	wire [3:0] eff;
	assign eff[0] = am[0] & ~(comb && psel == 2'h0);
	assign eff[1] = am[1] & ~(comb && psel == 2'h1);
	assign eff[2] = am[2] & ~(comb && psel == 2'h2);
	assign eff[3] = comb ? comb_m : dm;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_halt_r <= 1'b0;
			brk_event_r <= 1'b0;
			hit_r <= 4'h0;
		end else begin
			brk_halt_r <= |(eff & cfg[CF_HALT +: 4]);
			brk_event_r <= |(eff & cfg[CF_EVT +: 4]);
			hit_r <= eff;
		end
	end
endmodule

// File: core/debug_unit.sv
`timescale 1ns/1ns
module debug_unit
	import dbg_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Interrupt
	output logic irq,
	// Serial debug link
	input wire logic link_tck,
	input wire logic link_sel,
	input wire logic link_tdi,
	output logic link_tdo,
	// Debug event pin
	input wire logic event_in,
	output logic event_out,
	output logic event_oe,
	// Core access observation
	input wire logic acc_valid,
	input wire logic acc_write,
	input wire logic [2:0] acc_space,
	input wire logic [15:0] acc_addr,
	input wire logic [7:0] acc_data,
	// Core retire stream
	input wire logic instr_valid,
	input wire logic [15:0] instr_pc,
	// Core run control
	output logic core_halt,
	output logic core_reset,
	output logic core_step,
	output logic core_stall,
	// Cycle-stealing access port
	output logic dbg_req,
	output logic dbg_write,
	output logic [2:0] dbg_space,
	output logic [15:0] dbg_addr,
	output logic [7:0] dbg_wdata,
	input wire logic dbg_ack,
	input wire logic [7:0] dbg_rdata
);
	import dbg_pkg::*;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	logic [31:0] cfg_r;
	logic [31:0] bp_r [4];
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic irq_r;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Every pin crosses two flops; the second stage feeds logic, and a third flop on tck, sel and event_in feeds the edge detectors.
	logic [1:0] tck_s;
	logic [1:0] sel_s;
	logic [1:0] tdi_s;
	logic [1:0] evi_s;
	logic tck_d;
	logic sel_d;
	logic evi_d;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tck_s <= 2'h0;
			sel_s <= 2'h0;
			tdi_s <= 2'h0;
			evi_s <= 2'h3;
			tck_d <= 1'b0;
			sel_d <= 1'b0;
			evi_d <= 1'b1;
		end else begin
			tck_s <= {tck_s[0], link_tck};
			sel_s <= {sel_s[0], link_sel};
			tdi_s <= {tdi_s[0], link_tdi};
			evi_s <= {evi_s[0], event_in};
			tck_d <= tck_s[1];
			sel_d <= sel_s[1];
			evi_d <= evi_s[1];
		end
	end

	wire tck_rise = tck_s[1] & ~tck_d;
	wire tck_fall = ~tck_s[1] & tck_d;
	wire frame_start = sel_s[1] & ~sel_d;
	wire frame_end = ~sel_s[1] & sel_d;
	wire ev_input_mode = ~cfg_r[CF_EVOUT];
	wire ext_fall = ev_input_mode & evi_d & ~evi_s[1];

	// ---------------------------------------------------------------
	// Breakpoint logic
	// ---------------------------------------------------------------
	core_access_if acc ();
	assign acc.valid = acc_valid;
	assign acc.write = acc_write;
	assign acc.space = acc_space;
	assign acc.addr = acc_addr;
	assign acc.data = acc_data;

	logic brk_halt;
	logic brk_event;
	logic [3:0] bp_hit;

	bp_match u_bp (
		.pclk (pclk),
		.presetn (presetn),
		.acc (acc.mon),
		.bp_word (bp_r),
		.cfg (cfg_r),
		.brk_halt_r (brk_halt),
		.brk_event_r (brk_event),
		.hit_r (bp_hit)
	);

	wire any_break = brk_halt | brk_event;
	wire ext_halt = ext_fall & cfg_r[CF_EVHALT];

	// ---------------------------------------------------------------
	// Serial frame shifters
	// ---------------------------------------------------------------
	logic [FRAME_W-1:0] in_sr_r;
	logic [FRAME_W-1:0] out_sr_r;
	logic tdo_r;

	wire op_e cmd_op = op_e'(in_sr_r[FR_OP +: 4]);
	wire do_cmd = frame_end;
	wire is_mem_op = (cmd_op == OP_READ) || (cmd_op == OP_WRITE);

	// ---------------------------------------------------------------
	// Run control and trace state
	// ---------------------------------------------------------------
	logic halt_r;
	logic reset_r;
	logic step_r;
	logic stall_r;
	logic trace_v_r;
	logic [15:0] trace_pc_r;
	logic req_r;
	logic req_wr_r;
	logic [2:0] req_space_r;
	logic [15:0] req_addr_r;
	logic [7:0] req_wdata_r;
	logic rdata_v_r;
	logic [7:0] rdata_r;
	logic ev_out_r;

	wire trace_en = cfg_r[CF_TRACE];
	wire [FRAME_W-1:0] out_word = {trace_v_r, halt_r, rdata_v_r, 5'h00, trace_pc_r,
		rdata_r, 8'h00};

	// Data is taken on the link clock's rising edge and driven on its falling one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_sr_r <= '0;
			out_sr_r <= '0;
			tdo_r <= 1'b0;
		end else if (frame_start) begin
			out_sr_r <= out_word;
			tdo_r <= out_word[FRAME_W-1];
		end else if (sel_s[1]) begin
			if (tck_rise) begin
				in_sr_r <= {in_sr_r[FRAME_W-2:0], tdi_s[1]};
			end
			if (tck_fall) begin
				out_sr_r <= {out_sr_r[FRAME_W-2:0], 1'b0};
				tdo_r <= out_sr_r[FRAME_W-2];
			end
		end
	end

	// Halt is sticky; breaks and external events may only set it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_r <= 1'b0;
			reset_r <= 1'b0;
			step_r <= 1'b0;
		end else begin
			reset_r <= do_cmd && cmd_op == OP_RESET;
			step_r <= do_cmd && cmd_op == OP_STEP && halt_r;
			if (brk_halt || ext_halt || (do_cmd && cmd_op == OP_HALT)) begin
				halt_r <= 1'b1;
			end else if (do_cmd && cmd_op == OP_RUN) begin
				halt_r <= 1'b0;
			end
		end
	end

	// One trace record is held at a time; the core waits until a frame
	// has taken it, so tracing limits the core to the link's frame rate.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trace_v_r <= 1'b0;
			trace_pc_r <= 16'h0000;
			stall_r <= 1'b0;
		end else begin
			if (trace_en && instr_valid) begin
				trace_v_r <= 1'b1;
				trace_pc_r <= instr_pc;
			end else if (frame_start) begin
				trace_v_r <= 1'b0;
			end
			stall_r <= trace_en & ((trace_v_r & ~frame_start) | instr_valid);
		end
	end

	// The core serves the request in a spare cycle while it keeps running.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_r <= 1'b0;
			req_wr_r <= 1'b0;
			req_space_r <= 3'h0;
			req_addr_r <= 16'h0000;
			req_wdata_r <= 8'h00;
		end else if (req_r) begin
			if (dbg_ack) begin
				req_r <= 1'b0;
			end
		end else if (do_cmd && is_mem_op) begin
			req_r <= 1'b1;
			req_wr_r <= cmd_op == OP_WRITE;
			req_space_r <= in_sr_r[FR_SPACE +: 3];
			req_addr_r <= in_sr_r[FR_ADDR +: 16];
			req_wdata_r <= in_sr_r[FR_DATA +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_v_r <= 1'b0;
			rdata_r <= 8'h00;
		end else if (req_r && dbg_ack && !req_wr_r) begin
			rdata_v_r <= 1'b1;
			rdata_r <= dbg_rdata;
		end else if (frame_start) begin
			rdata_v_r <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Event pin
	// ---------------------------------------------------------------
	// A break is a one-cycle flag from the comparators, so one pulse each.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_out_r <= 1'b0;
		end else begin
			ev_out_r <= cfg_r[CF_EVOUT] & brk_event;
		end
	end

	// ---------------------------------------------------------------
	// APB slave
	// ---------------------------------------------------------------
	wire setup = psel & ~penable;
	wire access = psel & penable & pready_r;
	wire wr_acc = access & pwrite;
	wire [1:0] bp_idx = paddr[3:2];
	wire is_bp = (paddr >= ADDR_BP0) && (paddr <= ADDR_BP3) && (paddr[1:0] == 2'h0);
	wire is_cfg = paddr == ADDR_CFG;
	wire is_stat = paddr == ADDR_STATUS;
	wire is_istat = paddr == ADDR_IRQ_STAT;
	wire is_imask = paddr == ADDR_IRQ_MASK;
	wire mapped = is_bp | is_cfg | is_stat | is_istat | is_imask;
	wire [31:0] status_word = {20'h00000, bp_hit, 1'b0, rdata_v_r, req_r, trace_v_r,
		stall_r, evi_d, halt_r, halt_r};
	wire [31:0] rd_mux = is_cfg ? cfg_r :
		is_stat ? status_word :
		is_istat ? {29'h0, irq_stat_r} :
		is_imask ? {29'h0, irq_mask_r} :
		is_bp ? bp_r[bp_idx] : 32'h0000_0000;
	wire [2:0] irq_set = {req_r & dbg_ack, ext_fall, any_break};
	wire [2:0] irq_clr = (wr_acc && is_istat) ? pwdata[2:0] : 3'h0;

	// Zero wait states: pready rises in the first access cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= setup;
			pslverr_r <= setup & ~mapped;
			if (setup && !pwrite) begin
				prdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= CFG_RST;
			irq_mask_r <= IRQ_MASK_RST;
		end else if (wr_acc) begin
			if (is_cfg) begin
				cfg_r <= pwdata;
			end
			if (is_imask) begin
				irq_mask_r <= pwdata[2:0];
			end
		end
	end

	for (genvar i = 0; i < 4; i++) begin : g_bp
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				bp_r[i] <= BP_RST;
			end else if (wr_acc && is_bp && bp_idx == 2'(i)) begin
				bp_r[i] <= pwdata;
			end
		end
	end

	// A new event in the clearing cycle keeps its bit set.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 3'h0;
			irq_r <= 1'b0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign irq = irq_r;
	assign link_tdo = tdo_r;
	assign event_out = ev_out_r;
	assign event_oe = cfg_r[CF_EVOUT];
	assign core_halt = halt_r;
	assign core_reset = reset_r;
	assign core_step = step_r;
	assign core_stall = stall_r;
	assign dbg_req = req_r;
	assign dbg_write = req_wr_r;
	assign dbg_space = req_space_r;
	assign dbg_addr = req_addr_r;
	assign dbg_wdata = req_wdata_r;
endmodule

// File: dv/jtag_probe.sv
`timescale 1ns/1ns
module jtag_probe (
	// Link pins
	output logic link_tck,
	output logic link_sel,
	output logic link_tdi,
	input wire logic link_tdo
);
	logic [39:0] rx;
	initial begin
		link_tck = 1'b0;
		link_sel = 1'b0;
		link_tdi = 1'b0;
	end
	// ----------------------------------------------------------------
	// Frame
	// ----------------------------------------------------------------
	// The clock stands still between frames, and the data line flips after release
	// so that a stale bit is never taken for a driven one.
	task automatic frame(input logic [39:0] tx);
		#37 link_sel = 1'b1;
		#400;
		for (int i = 39; i >= 0; i--) begin
			link_tdi = tx[i];
			#200 link_tck = 1'b1;
			#150 rx[i] = link_tdo;
			#50 link_tck = 1'b0;
		end
		#400 link_sel = 1'b0;
		link_tdi = ~link_tdi;
		#800;
	endtask
endmodule

// File: dv/debug_unit_props.sv
`timescale 1ns/1ns
module debug_unit_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Watched ports
	input wire logic event_out,
	input wire logic event_oe,
	input wire logic acc_valid,
	input wire logic instr_valid,
	input wire logic core_halt,
	input wire logic core_reset,
	input wire logic core_step,
	input wire logic core_stall,
	input wire logic dbg_req,
	input wire logic dbg_ack,
	input wire logic dbg_write,
	input wire logic [2:0] dbg_space,
	input wire logic [15:0] dbg_addr,
	input wire logic [7:0] dbg_wdata
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_event_one_cycle: assert property (event_out |=> !event_out)
		else $error("event pulse lasted more than one cycle");
	a_event_out_mode: assert property (event_out |-> event_oe)
		else $error("event pulse while pin not driven");
	a_event_from_access: assert property (event_out |-> $past(acc_valid, 2))
		else $error("event pulse without an access two cycles before");
	a_step_when_halted: assert property (core_step |-> core_halt)
		else $error("step pulse while core running");
	a_reset_pulse: assert property (core_reset |=> !core_reset)
		else $error("core reset longer than one cycle");
	a_stall_after_retire: assert property ($rose(core_stall) |-> $past(instr_valid))
		else $error("stall began without a retired instruction");
	a_req_held: assert property (dbg_req && !dbg_ack |=> dbg_req && $stable({dbg_write,
		dbg_space, dbg_addr, dbg_wdata}))
		else $error("stolen access request changed before acknowledge");
	a_req_drop: assert property (dbg_ack |=> !dbg_req)
		else $error("stolen access request held after acknowledge");
endmodule
bind debug_unit debug_unit_props chk_u (.pclk(pclk), .presetn(presetn), .event_out(event_out),
	.event_oe(event_oe), .acc_valid(acc_valid), .instr_valid(instr_valid),
	.core_halt(core_halt), .core_reset(core_reset), .core_step(core_step),
	.core_stall(core_stall), .dbg_req(dbg_req), .dbg_ack(dbg_ack), .dbg_write(dbg_write),
	.dbg_space(dbg_space), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata));

// File: dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import dbg_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr, ext_ev, irq_on;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic link_tck, link_sel, link_tdi, link_tdo, event_out, event_oe, acc_valid, acc_write;
	logic instr_valid, core_halt, core_reset, core_step, core_stall, dbg_req, dbg_write, dbg_ack;
	logic [2:0] acc_space, dbg_space;
	logic [15:0] acc_addr, instr_pc, dbg_addr;
	logic [7:0] acc_data, dbg_wdata, dbg_rdata;
	logic [27:0] seen;
	wire logic event_in;
	int n_errors, n_compared, n_ev, n_step, n_rst;
	// The event pin is pulled up; whoever enables a driver owns its level.
	assign event_in = event_oe ? event_out : ext_ev;
	debug_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .link_tck(link_tck), .link_sel(link_sel),
		.link_tdi(link_tdi), .link_tdo(link_tdo), .event_in(event_in), .event_out(event_out),
		.event_oe(event_oe), .acc_valid(acc_valid), .acc_write(acc_write),
		.acc_space(acc_space), .acc_addr(acc_addr), .acc_data(acc_data),
		.instr_valid(instr_valid), .instr_pc(instr_pc), .core_halt(core_halt),
		.core_reset(core_reset), .core_step(core_step), .core_stall(core_stall),
		.dbg_req(dbg_req), .dbg_write(dbg_write), .dbg_space(dbg_space), .dbg_addr(dbg_addr),
		.dbg_wdata(dbg_wdata), .dbg_ack(dbg_ack), .dbg_rdata(dbg_rdata));
	jtag_probe probe_u (.link_tck(link_tck), .link_sel(link_sel), .link_tdi(link_tdi),
		.link_tdo(link_tdo));
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// ----------------------------------------------------------------
	// Core side: acknowledges stolen cycles one cycle late, counts pulses
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		dbg_ack <= dbg_req & ~dbg_ack;
		dbg_rdata <= ~dbg_addr[7:0];
		if (dbg_req & ~dbg_ack) seen <= {dbg_write, dbg_space, dbg_addr, dbg_wdata};
		if (event_out === 1'b1) n_ev++;
		if (core_step === 1'b1) n_step++;
		if (core_reset === 1'b1) n_rst++;
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			n_errors++;
			print_verdict();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so a following call never raises psel in the same step.
		@(posedge pclk);
	endtask
	task automatic send(input op_e op, input logic [2:0] sp, input logic [15:0] a,
		input logic [7:0] d);
		probe_u.frame({op, sp, 1'b0, a, 8'h00, d});
		@(posedge pclk);
	endtask
	// One core access, then the sticky break flag and the interrupt are judged and cleared.
	task automatic hit(input logic wr, input logic [2:0] sp, input logic [15:0] a,
		input logic [7:0] d, input logic exp);
		acc_valid <= 1'b1;
		acc_write <= wr;
		acc_space <= sp;
		acc_addr <= a;
		acc_data <= d;
		@(posedge pclk);
		acc_valid <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, ADDR_IRQ_STAT, 0);
		check("break flag", 40'(exp), 40'(rdata[IRQ_BRK]));
		check("irq", 40'(exp & irq_on), 40'(irq));
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0007);
		repeat (2) @(posedge pclk);
		check("irq cleared", 0, 40'(irq));
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		apb(1'b0, ADDR_CFG, 0);
		check("cfg reset", CFG_RST, rdata);
		apb(1'b0, ADDR_BP3, 0);
		check("bp3 reset", BP_RST, rdata);
		apb(1'b0, ADDR_IRQ_MASK, 0);
		check("mask reset", 40'(IRQ_MASK_RST), 40'(rdata[2:0]));
		apb(1'b1, 12'h020, 32'hFFFF_FFFF);
		check("unmapped error", 1, 40'(rerr));
		apb(1'b0, 12'h020, 0);
		check("unmapped data", 0, rdata);
		check("pin input mode", 0, 40'(event_oe));
		$display("t_regs done");
	endtask
	task automatic t_brk;
		irq_on = 1'b1;
		apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
		apb(1'b1, ADDR_BP0, 32'h8500_1234);
		apb(1'b1, ADDR_BP0 + 12'h004, 32'h0B00_0010);
		apb(1'b1, ADDR_CFG, 32'h0000_1358);
		hit(1'b1, SP_EXT, 16'h1234, 8'h00, 1'b1);
		check("event pulses", 1, n_ev);
		check("break halt", 1, 40'(core_halt));
		hit(1'b0, SP_EXT, 16'h1234, 8'h00, 1'b0);
		hit(1'b1, SP_SFR, 16'h1234, 8'h00, 1'b0);
		hit(1'b0, SP_CODE, 16'h0011, 8'h00, 1'b0);
		irq_on = 1'b0;
		apb(1'b1, ADDR_IRQ_MASK, 0);
		hit(1'b0, SP_CODE, 16'h0010, 8'h00, 1'b1);
		check("event only bp0", 1, n_ev);
		$display("t_brk done");
	endtask
	task automatic t_range;
		apb(1'b1, ADDR_BP0, 32'hFF00_0100);
		apb(1'b1, ADDR_BP0 + 12'h004, 32'hFF00_0200);
		apb(1'b1, ADDR_CFG, 32'h0000_0119);
		hit(1'b1, SP_EXT, 16'h0150, 8'h00, 1'b1);
		hit(1'b1, SP_EXT, 16'h0300, 8'h00, 1'b0);
		apb(1'b1, ADDR_CFG, 32'h0000_011B);
		hit(1'b0, SP_CODE, 16'h0150, 8'h00, 1'b0);
		hit(1'b0, SP_CODE, 16'h0300, 8'h00, 1'b1);
		$display("t_range done");
	endtask
	task automatic t_comb;
		apb(1'b1, ADDR_BP0, 32'h8500_0055);
		apb(1'b1, ADDR_BP0 + 12'h004, 0);
		apb(1'b1, ADDR_BP3, 32'h85A5_0055);
		apb(1'b1, ADDR_CFG, 32'h0000_0824);
		hit(1'b1, SP_EXT, 16'h0055, 8'hA5, 1'b1);
		hit(1'b1, SP_EXT, 16'h0055, 8'h5A, 1'b0);
		apb(1'b1, ADDR_CFG, 32'h0000_0820);
		hit(1'b1, SP_EXT, 16'h0055, 8'h5A, 1'b1);
		$display("t_comb done");
	endtask
	task automatic t_run;
		apb(1'b1, ADDR_CFG, 0);
		send(OP_HALT, SP_CODE, 0, 0);
		check("halt", 1, 40'(core_halt));
		send(OP_STEP, SP_CODE, 0, 0);
		check("step pulses", 1, n_step);
		check("halted flag", 1, 40'(probe_u.rx[FO_HALTED]));
		send(OP_RUN, SP_CODE, 0, 0);
		check("resume", 0, 40'(core_halt));
		send(OP_STEP, SP_CODE, 0, 0);
		check("step ignored", 1, n_step);
		send(OP_RESET, SP_CODE, 0, 0);
		check("reset pulses", 1, n_rst);
		$display("t_run done");
	endtask
	task automatic t_access;
		for (int s = 0; s < 6; s++) begin
			send(OP_WRITE, 3'(s), 16'h0040 + 16'(s), 8'hC0 + 8'(s));
			check("stolen write", {1'b1, 3'(s), 16'h0040 + 16'(s), 8'hC0 + 8'(s)}, 40'(seen));
		end
		send(OP_READ, SP_EXT, 16'h0077, 8'h00);
		send(OP_NOP, SP_CODE, 0, 0);
		check("read valid", 1, 40'(probe_u.rx[FO_RDATA_V]));
		check("read data", 40'h88, 40'(probe_u.rx[FO_RDATA +: 8]));
		$display("t_access done");
	endtask
	task automatic t_trace;
		apb(1'b1, ADDR_CFG, 32'h0001_0000);
		instr_valid <= 1'b1;
		instr_pc <= 16'hBEEF;
		@(posedge pclk);
		instr_valid <= 1'b0;
		repeat (2) @(posedge pclk);
		check("stall", 1, 40'(core_stall));
		send(OP_NOP, SP_CODE, 0, 0);
		check("trace valid", 1, 40'(probe_u.rx[FO_TRACE_V]));
		check("trace pc", 40'hBEEF, 40'(probe_u.rx[FO_PC +: 16]));
		check("stall end", 0, 40'(core_stall));
		$display("t_trace done");
	endtask
	task automatic t_evin;
		apb(1'b1, ADDR_CFG, 32'h0000_0080);
		send(OP_RUN, SP_CODE, 0, 0);
		apb(1'b1, ADDR_IRQ_STAT, 32'h0000_0007);
		ext_ev <= 1'b0;
		repeat (8) @(posedge pclk);
		apb(1'b0, ADDR_IRQ_STAT, 0);
		check("external break", 1, 40'(rdata[IRQ_EXT]));
		check("external halt", 1, 40'(core_halt));
		ext_ev <= 1'b1;
		$display("t_evin done");
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, irq_on} = '0;
		{acc_valid, acc_write, acc_space, acc_addr, acc_data, instr_valid, instr_pc} = '0;
		{dbg_ack, dbg_rdata} = '0;
		ext_ev = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_brk();
		t_range();
		t_comb();
		t_run();
		t_access();
		t_trace();
		t_evin();
		print_verdict();
	end
	initial begin
		#3000000;
		n_errors++;
		print_verdict();
	end
endmodule
